// ===== hw/dmbd_defs.svh
// constants for the mode register zero/one burst and dll block
`ifndef DMBD_DEFS_SVH
`define DMBD_DEFS_SVH
`define DMBD_SEL_MODE0    3'h0
`define DMBD_SEL_MODE1    3'h1
`define DMBD_SEL_IGNORE   3'h7
`define DMBD_BL_LO        0
`define DMBD_BT_BIT       3
`define DMBD_TM_BIT       7
`define DMBD_DLLRST_BIT   8
`define DMBD_WR_LO        9
`define DMBD_OTF_BIT      12
`define DMBD_AP_BIT       10
`define DMBD_DLLEN_BIT    0
`define DMBD_AL_LO        3
`define DMBD_BL_EIGHT     2'h0
`define DMBD_BL_OTF       2'h1
`define DMBD_BL_CHOP      2'h2
`define DMBD_CL_BASE      8'h09
`define DMBD_WR_LAT       8'h09
`define DMBD_TRP_CLKS     8'h0F
`define DMBD_DLL_LOCK     10'h300
`define DMBD_SLOTS        4'h8
`define DMBD_EIGHT_REF    4'h7
`define DMBD_CHOP_REF     4'h5
`define DMBD_FIFO_W       11
`define DMBD_FIFO_D       16
`endif

// ===== hw/dmbd_pkg.sv
// types shared by the mode register zero/one burst and dll block
package dmbd_pkg;
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
    logic [7:0]  dq;
    logic        byte_mask;
  } dmbd_pins_t;

  typedef enum logic [2:0] {
    DMBD_NOP, DMBD_MRS, DMBD_RD, DMBD_WR, DMBD_SRE, DMBD_SRX
  } dmbd_cmd_t;

  typedef struct packed {
    logic [2:0]      ck;
    logic            last_cke;
    dmbd_pins_t      p1;
    dmbd_pins_t      p2;
    logic [17:0]     mode0;
    logic [17:0]     mode1;
    logic            dll_on;
    logic [9:0]      lock_cnt;
    logic            locked;
    logic [7:0]      rd_wait;
    logic [3:0]      rd_slot;
    logic [2:0]      rd_col;
    logic            rd_il;
    logic            rd_chop;
    logic [7:0]      wr_wait;
    logic [3:0]      wr_slot;
    logic            wr_col2;
    logic            wr_chop;
    logic            wr_fix;
    logic            wr_ap;
    logic [7:0][7:0] wbuf;
    logic [7:0]      wmask;
    logic            committing;
    logic [3:0]      commit_idx;
    logic [7:0]      recov;
    logic [7:0][7:0] mem;
    logic [7:0]      dq;
    logic            dq_oe_n;
    logic            dqs;
  } dmbd_state_t;
endpackage : dmbd_pkg

// ===== hw/dmbd_top.sv
// burst ordering, mode register zero/one decode and dll control
`timescale 1ns/10ps
`include "dmbd_defs.svh"

module dmbd_fifo #(
  parameter int WIDTH = `DMBD_FIFO_W,
  parameter int DEPTH = `DMBD_FIFO_D
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] buf_r;
  logic [AW-1:0]               wp_r;
  logic [AW-1:0]               rp_r;
  logic [AW:0]                 cnt_r;
  logic                        push;
  logic                        pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = buf_r[rp_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wp_r] <= i_in_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : dmbd_fifo

module dmbd_top (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  wire logic                i_link_ck,
  input  wire dmbd_pkg::dmbd_pins_t i_pins,
  input  wire logic                i_wr_crc_en,
  input  wire logic                i_byte_mask_en,
  input  wire logic                i_crc_ok,
  input  wire logic                i_write_term_en,
  input  wire logic                i_array_ready,
  output logic [7:0]               o_dq,
  output logic                     o_dq_oe_n,
  output logic                     o_dqs,
  output logic                     o_dqs_oe_n,
  output logic                     o_interleaved,
  output logic [1:0]               o_burst_mode,
  output logic [7:0]               o_total_read_latency,
  output logic                     o_dll_active,
  output logic                     o_dll_locked,
  output logic                     o_bank_busy,
  output logic                     o_write_busy
);
  dmbd_pkg::dmbd_state_t s_r;
  dmbd_pkg::dmbd_state_t s_nxt;
  dmbd_pkg::dmbd_cmd_t   cmd;
  logic                  edge_hit;
  logic                  f_in_valid;
  logic                  f_in_ready;
  logic [10:0]           f_in_data;
  logic                  f_out_valid;
  logic [10:0]           f_out_data;

  function automatic logic [2:0] read_col(input logic [2:0] start,
                                          input logic [2:0] beat,
                                          input logic       il);
    if (il)
      read_col = start ^ beat;
    else
      read_col = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
  endfunction : read_col

  function automatic logic [7:0] recov_clks(input logic [2:0] code);
    case (code)
      3'h0: recov_clks = 8'h0A;
      3'h1: recov_clks = 8'h0C;
      3'h2: recov_clks = 8'h0E;
      3'h3: recov_clks = 8'h10;
      3'h4: recov_clks = 8'h12;
      3'h5: recov_clks = 8'h14;
      default: recov_clks = 8'h18;
    endcase
  endfunction : recov_clks

  function automatic logic [7:0] rtp_clks(input logic [2:0] code);
    case (code)
      3'h6: rtp_clks = 8'h0C;
      3'h7: rtp_clks = 8'h0C;
      default: rtp_clks = 8'(8'h05 + {5'h00, code});
    endcase
  endfunction : rtp_clks

  function automatic logic [7:0] read_lat(input logic [17:0] m0,
                                          input logic [17:0] m1);
    logic [7:0] cl;
    cl = 8'(`DMBD_CL_BASE + {3'h0, m0[12], m0[6:4], m0[2]});
    case (m1[`DMBD_AL_LO +: 2])
      2'h1: read_lat = 8'(cl + cl - 8'h01);
      2'h2: read_lat = 8'(cl + cl - 8'h02);
      default: read_lat = cl;
    endcase
  endfunction : read_lat

  assign edge_hit = s_r.ck[1] & ~s_r.ck[2];

  always_comb
  begin
    cmd = dmbd_pkg::DMBD_NOP;
    // cke rise between two link edges
    if (s_r.p2.cke & ~s_r.last_cke)
      cmd = dmbd_pkg::DMBD_SRX;
    else if (!s_r.p2.cs_n && s_r.p2.act_n)
    begin
      case ({s_r.p2.ras_n, s_r.p2.cas_n, s_r.p2.we_n})
        3'h0: cmd = dmbd_pkg::DMBD_MRS;
        3'h1: cmd = s_r.p2.cke ? dmbd_pkg::DMBD_NOP : dmbd_pkg::DMBD_SRE;
        3'h4: cmd = dmbd_pkg::DMBD_WR;
        3'h5: cmd = dmbd_pkg::DMBD_RD;
        default: cmd = dmbd_pkg::DMBD_NOP;
      endcase
    end
  end

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.ck = {s_r.ck[1:0], i_link_ck};
    s_nxt.p1 = i_pins;
    s_nxt.p2 = s_r.p1;
    f_in_valid = 1'b0;
    f_in_data  = {s_r.commit_idx[2:0], s_r.wbuf[s_r.commit_idx[2:0]]};
    if (f_out_valid && i_array_ready)
      s_nxt.mem[f_out_data[10:8]] = f_out_data[7:0];
    if (s_r.committing)
    begin
      if (s_r.commit_idx == `DMBD_SLOTS)
        s_nxt.committing = 1'b0;
      else if (s_r.wmask[s_r.commit_idx[2:0]])
        s_nxt.commit_idx = s_r.commit_idx + 4'h1;
      else
      begin
        f_in_valid = 1'b1;
        if (f_in_ready)
          s_nxt.commit_idx = s_r.commit_idx + 4'h1;
      end
    end
    if (edge_hit)
    begin
      s_nxt.last_cke = s_r.p2.cke;
      if (s_r.recov != 8'h00)
        s_nxt.recov = s_r.recov - 8'h01;
      if (s_r.lock_cnt != 10'h000)
      begin
        s_nxt.lock_cnt = s_r.lock_cnt - 10'h001;
        s_nxt.locked   = (s_r.lock_cnt == 10'h001);
      end
      // read beats
      if (s_r.rd_slot != 4'h0)
      begin
        s_nxt.dq = s_r.mem[read_col(s_r.rd_col, s_r.rd_slot[2:0],
                                    s_r.rd_il)];
        s_nxt.dq_oe_n = s_r.rd_chop & s_r.rd_slot[2];
        s_nxt.dqs     = ~s_r.dqs;
        s_nxt.rd_slot = s_r.rd_slot + 4'h1;
        if (s_r.rd_slot == `DMBD_SLOTS)
        begin
          s_nxt.rd_slot = 4'h0;
          s_nxt.dq_oe_n = 1'b1;
          s_nxt.dqs     = 1'b0;
        end
      end
      if (s_r.rd_wait != 8'h00)
      begin
        s_nxt.rd_wait = s_r.rd_wait - 8'h01;
        if (s_r.rd_wait == 8'h01)
        begin
          s_nxt.dq      = s_r.mem[s_r.rd_col];
          s_nxt.dq_oe_n = 1'b0;
          s_nxt.dqs     = 1'b1;
          s_nxt.rd_slot = 4'h1;
        end
      end
      // write beats, in column order
      if (s_r.wr_slot != 4'h0)
      begin
        // slot eight and chopped tail beats carry no data
        if (!s_r.wr_slot[3] && (!s_r.wr_chop || !s_r.wr_slot[2]))
        begin
          s_nxt.wbuf[{s_r.wr_chop ? s_r.wr_col2 : s_r.wr_slot[2],
                      s_r.wr_slot[1:0]}] = s_r.p2.dq;
          s_nxt.wmask[{s_r.wr_chop ? s_r.wr_col2 : s_r.wr_slot[2],
                       s_r.wr_slot[1:0]}] = s_r.p2.byte_mask;
        end
        if (s_r.wr_ap && s_r.wr_slot ==
            (s_r.wr_fix ? `DMBD_CHOP_REF : `DMBD_EIGHT_REF))
          s_nxt.recov = 8'(recov_clks(s_r.mode0[`DMBD_WR_LO +: 3])
                           + `DMBD_TRP_CLKS);
        s_nxt.wr_slot = s_r.wr_slot + 4'h1;
        if (s_r.wr_slot == `DMBD_SLOTS)
        begin
          s_nxt.wr_slot    = 4'h0;
          s_nxt.commit_idx = 4'h0;
          s_nxt.committing = ~(i_wr_crc_en & i_byte_mask_en & ~i_crc_ok);
        end
      end
      if (s_r.wr_wait != 8'h00)
      begin
        s_nxt.wr_wait = s_r.wr_wait - 8'h01;
        if (s_r.wr_wait == 8'h01)
        begin
          s_nxt.wr_slot = 4'h1;
          s_nxt.wmask   = 8'hFF;
          s_nxt.wbuf[{s_r.wr_chop & s_r.wr_col2, 2'h0}] = s_r.p2.dq;
          s_nxt.wmask[{s_r.wr_chop & s_r.wr_col2, 2'h0}] = s_r.p2.byte_mask;
        end
      end
      case (cmd)
        dmbd_pkg::DMBD_MRS:
        begin
          if ({s_r.p2.bg[0], s_r.p2.ba} == `DMBD_SEL_MODE0)
          begin
            s_nxt.mode0 = s_r.p2.addr;
            s_nxt.mode0[`DMBD_DLLRST_BIT] = 1'b0;
            if (s_r.p2.addr[`DMBD_DLLRST_BIT])
            begin
              s_nxt.lock_cnt = `DMBD_DLL_LOCK;
              s_nxt.locked   = 1'b0;
            end
          end
          else if ({s_r.p2.bg[0], s_r.p2.ba} == `DMBD_SEL_MODE1)
          begin
            s_nxt.mode1  = s_r.p2.addr;
            s_nxt.dll_on = s_r.p2.addr[`DMBD_DLLEN_BIT];
          end
        end
        dmbd_pkg::DMBD_RD:
        begin
          s_nxt.rd_wait = read_lat(s_r.mode0, s_r.mode1);
          s_nxt.rd_col  = s_r.p2.addr[2:0];
          s_nxt.rd_il   = s_r.mode0[`DMBD_BT_BIT];
          s_nxt.rd_chop = (s_r.mode0[1:0] == `DMBD_BL_CHOP) ||
                          ((s_r.mode0[1:0] == `DMBD_BL_OTF) &&
                           !s_r.p2.addr[`DMBD_OTF_BIT]);
          if (s_r.p2.addr[`DMBD_AP_BIT])
            s_nxt.recov = 8'(rtp_clks(s_r.mode0[`DMBD_WR_LO +: 3])
                             + `DMBD_TRP_CLKS);
        end
        dmbd_pkg::DMBD_WR:
        begin
          if (!i_write_term_en || s_r.locked)
          begin
            s_nxt.wr_wait = `DMBD_WR_LAT;
            s_nxt.wr_col2 = s_r.p2.addr[2];
            s_nxt.wr_ap   = s_r.p2.addr[`DMBD_AP_BIT];
            s_nxt.wr_fix  = (s_r.mode0[1:0] == `DMBD_BL_CHOP);
            s_nxt.wr_chop = (s_r.mode0[1:0] == `DMBD_BL_CHOP) ||
                            ((s_r.mode0[1:0] == `DMBD_BL_OTF) &&
                             !s_r.p2.addr[`DMBD_OTF_BIT]);
          end
        end
        dmbd_pkg::DMBD_SRE:
        begin
          s_nxt.dll_on = 1'b0;
          s_nxt.locked = 1'b0;
        end
        dmbd_pkg::DMBD_SRX:
          s_nxt.dll_on = s_r.mode1[`DMBD_DLLEN_BIT];
        default:
          s_nxt.dll_on = s_r.dll_on;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_r          <= '0;
      s_r.dq_oe_n  <= 1'b1;
      s_r.last_cke <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  dmbd_fifo #(
    .WIDTH (`DMBD_FIFO_W),
    .DEPTH (`DMBD_FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (f_in_valid),
    .o_in_ready  (f_in_ready),
    .i_in_data   (f_in_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (i_array_ready),
    .o_out_data  (f_out_data)
  );

  assign o_dq                 = s_r.dq;
  assign o_dq_oe_n            = s_r.dq_oe_n;
  assign o_dqs                = s_r.dqs;
  assign o_dqs_oe_n           = s_r.dq_oe_n;
  assign o_interleaved        = s_r.mode0[`DMBD_BT_BIT];
  assign o_burst_mode         = s_r.mode0[1:0];
  assign o_total_read_latency = read_lat(s_r.mode0, s_r.mode1);
  assign o_dll_active         = s_r.dll_on;
  assign o_dll_locked         = s_r.locked;
  assign o_bank_busy          = (s_r.recov != 8'h00);
  assign o_write_busy         = s_r.committing | f_out_valid;

  sequence s_edge_mrs0;
    edge_hit && cmd == dmbd_pkg::DMBD_MRS
      && {s_r.p2.bg[0], s_r.p2.ba} == `DMBD_SEL_MODE0;
  endsequence

  a_mode0_load: assert property (
    @(posedge i_clk) disable iff (i_srst)
    s_edge_mrs0 |=> s_r.mode0[1:0] == $past(s_r.p2.addr[1:0]))
    else $error("mode zero not loaded");

  a_dllrst_clear: assert property (
    @(posedge i_clk) disable iff (i_srst)
    s_edge_mrs0 ##0 s_r.p2.addr[`DMBD_DLLRST_BIT]
    |=> !s_r.mode0[`DMBD_DLLRST_BIT] && !o_dll_locked
        && s_r.lock_cnt == `DMBD_DLL_LOCK)
    else $error("dll reset bit stuck");

  a_ignore_sel: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && cmd == dmbd_pkg::DMBD_MRS
      && {s_r.p2.bg[0], s_r.p2.ba} == `DMBD_SEL_IGNORE
    |=> $stable(s_r.mode0) && $stable(s_r.mode1))
    else $error("ignored select changed state");

  a_chop_float: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && s_r.rd_chop && s_r.rd_slot >= 4'h4
    |=> o_dq_oe_n && o_dqs_oe_n)
    else $error("chop read drives late slots");

  a_il_order: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && s_r.rd_il && s_r.rd_slot != 4'h0
    |=> o_dq == $past(s_r.mem[s_r.rd_col ^ s_r.rd_slot[2:0]]))
    else $error("interleaved order wrong");

  a_sr_dll_off: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && cmd == dmbd_pkg::DMBD_SRE |=> !o_dll_active)
    else $error("dll still on in self refresh");

  a_crc_discard: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && s_r.wr_slot == `DMBD_SLOTS
      && i_wr_crc_en && i_byte_mask_en && !i_crc_ok
    |=> !s_r.committing)
    else $error("bad crc write committed");

  a_term_refuse: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && cmd == dmbd_pkg::DMBD_WR && i_write_term_en
      && !s_r.locked && s_r.wr_wait == 8'h00
    |=> s_r.wr_wait == 8'h00)
    else $error("write taken without lock");

  a_read_start: assert property (
    @(posedge i_clk) disable iff (i_srst)
    edge_hit && s_r.rd_wait == 8'h01 |=> !o_dq_oe_n ##0 s_r.rd_slot == 4'h1)
    else $error("read data not started at latency");
endmodule : dmbd_top

// ===== test/dmbd_ctl_model.sv
// controller-side model: link clock, commands and write data
`timescale 1ns/10ps
module dmbd_ctl_model (
  output logic                 o_link_ck,
  output dmbd_pkg::dmbd_pins_t o_pins
);
  initial
  begin
    o_link_ck = 1'b0;
    o_pins = '0;
    o_pins.cke = 1'b1;
    o_pins.cs_n = 1'b1;
    o_pins.act_n = 1'b1;
  end
  // runs free like a memory clock; cke held high outside self refresh
  always #62.5 o_link_ck = ~o_link_ck;

  task automatic send(input logic [2:0] kind, input logic [2:0] sel,
                      input logic [17:0] a);
    @(negedge o_link_ck);
    o_pins.cs_n = 1'b0;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} = kind;
    o_pins.bg = {1'b0, sel[2]};
    o_pins.ba = sel[1:0];
    o_pins.addr = a;
    @(negedge o_link_ck);
    o_pins.cs_n = 1'b1;
    // deselected: no stale address
    o_pins.addr = ~a;
  endtask : send

  task automatic mrs(input logic [2:0] sel, input logic [17:0] a);
    logic [17:0] v;
    v = a;
    if (sel == 3'h0)
      v[7] = 1'b0;
    if (sel == 3'h1)
      {v[9], v[6], v[2]} = 3'h0;
    send(3'h0, sel, v);
    repeat (4) @(negedge o_link_ck);
  endtask : mrs

  task automatic wr(input logic [17:0] a, input logic [3:0] s);
    send(3'h4, 3'h0, a);
    repeat (8) @(negedge o_link_ck);
    for (int b = 0; b < 8; b++)
    begin
      o_pins.dq = {s, 1'b0, b[2:0]};
      if (b < 7)
        @(negedge o_link_ck);
    end
    @(negedge o_link_ck);
    // burst over: last beat must not stand
    o_pins.dq = ~o_pins.dq;
  endtask : wr

  task automatic sref(input logic enter);
    @(negedge o_link_ck);
    o_pins.cke = ~enter;
    o_pins.cs_n = ~enter;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} = 3'h1;
    @(negedge o_link_ck);
    o_pins.cs_n = 1'b1;
  endtask : sref
endmodule : dmbd_ctl_model

// ===== test/tb.sv
// testbench: mode decode, burst order, dll and recovery timing
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("mismatch t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end
module tb;
  logic                 clk, srst, link_ck, crc_en, mask_en, crc_ok;
  logic                 term_en, arr_rdy, dq_oe_n, dqs, dqs_oe_n, il;
  logic                 dll_on, locked, bank_busy, wr_busy;
  logic [7:0]           dq, rlat;
  logic [1:0]           bmode;
  dmbd_pkg::dmbd_pins_t pins;
  int                   err_total, compares, cyc, n, w0, r0;
  int                   wtab[7] = '{10, 12, 14, 16, 18, 20, 24};
  int                   rtab[7] = '{5, 6, 7, 8, 9, 10, 12};

  dmbd_ctl_model u_ctl (.o_link_ck(link_ck), .o_pins(pins));
  dmbd_top u_dut (.i_clk(clk), .i_srst(srst), .i_link_ck(link_ck),
    .i_pins(pins), .i_wr_crc_en(crc_en), .i_byte_mask_en(mask_en),
    .i_crc_ok(crc_ok), .i_write_term_en(term_en), .i_array_ready(arr_rdy),
    .o_dq(dq), .o_dq_oe_n(dq_oe_n), .o_dqs(dqs), .o_dqs_oe_n(dqs_oe_n),
    .o_interleaved(il), .o_burst_mode(bmode), .o_total_read_latency(rlat),
    .o_dll_active(dll_on), .o_dll_locked(locked), .o_bank_busy(bank_busy),
    .o_write_busy(wr_busy));

  always #2 clk = ~clk;

  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic at_clk();
    @(posedge clk);
    #1;
  endtask : at_clk

  task automatic wait_idle();
    // let the last write slot edge pass before looking
    repeat (2) @(negedge link_ck);
    for (int i = 0; i < 300 && wr_busy !== 1'b0; i++)
      @(negedge link_ck);
    `CHK(wr_busy, 1'b0)
  endtask : wait_idle

  // beat b of link edge k is sampled half a link period later
  task automatic rd_chk(input logic [17:0] a, input int rl, input logic bt,
                        input logic chop, input logic [3:0] s);
    logic [2:0] c;
    u_ctl.send(3'h5, 3'h0, a);
    repeat (rl) @(negedge link_ck);
    for (int b = 0; b < 8; b++)
    begin
      c = bt ? a[2:0] ^ b[2:0] : {a[2] ^ b[2], a[1:0] + b[1:0]};
      if (chop && b > 3)
        `CHK({dq_oe_n, dqs_oe_n}, 2'h3)
      else
        `CHK({dq_oe_n, dqs, dq}, {1'b0, ~b[0], s, 1'b0, c})
      @(negedge link_ck);
    end
    `CHK(dq_oe_n, 1'b1)
  endtask : rd_chk

  // link clocks from the task call until the bank window has closed
  task automatic busy_len();
    logic seen;
    seen = 1'b0;
    n = 0;
    while (n < 300 && !(seen && bank_busy === 1'b0))
    begin
      seen = seen | (bank_busy === 1'b1);
      @(negedge link_ck);
      n++;
    end
  endtask : busy_len

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    {crc_en, mask_en, term_en} = 3'h0;
    {crc_ok, arr_rdy} = 2'h3;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    repeat (10) @(posedge clk);
    `CHK({dq_oe_n, dll_on, locked, bmode, wr_busy, bank_busy}, 7'h40)
    u_ctl.wr(18'h00005, 4'hA);
    wait_idle();
    at_clk();
    term_en = 1'b1;
    u_ctl.wr(18'h00000, 4'h5);
    wait_idle();
    at_clk();
    term_en = 1'b0;
    u_ctl.mrs(3'h1, 18'h00001);
    `CHK(dll_on, 1'b1)
    u_ctl.mrs(3'h0, 18'h00100);
    for (int i = 0; i < 900 && locked !== 1'b1; i++)
      @(negedge link_ck);
    u_ctl.mrs(3'h0, 18'h00000);
    `CHK(locked, 1'b1)
    for (int bm = 0; bm < 3; bm++)
      for (int bt = 0; bt < 2; bt++)
      begin
        u_ctl.mrs(3'h0, {14'h0, bt[0], 1'b0, bm[1:0]});
        `CHK({il, bmode}, {bt[0], bm[1:0]})
        rd_chk({5'h0, bt[0], 9'h0, 3'(bm * 3 + bt * 5 + 1)}, 9, bt[0],
               bm == 2 || (bm == 1 && bt == 0), 4'hA);
      end
    u_ctl.mrs(3'h0, 18'h00000);
    u_ctl.mrs(3'h7, 18'h0000A);
    u_ctl.mrs(3'h2, 18'h0000A);
    u_ctl.mrs(3'h1, 18'h00009);
    `CHK({il, bmode}, 3'h0)
    u_ctl.mrs(3'h0, 18'h00004);
    `CHK(rlat, 8'h13)
    rd_chk(18'h00002, 19, 1'b0, 1'b0, 4'hA);
    u_ctl.mrs(3'h1, 18'h00001);
    u_ctl.mrs(3'h0, 18'h00000);
    `CHK(rlat, 8'h09)
    u_ctl.sref(1'b1);
    repeat (2) @(negedge link_ck);
    `CHK(dll_on, 1'b0)
    u_ctl.sref(1'b0);
    repeat (2) @(negedge link_ck);
    `CHK(dll_on, 1'b1)
    at_clk();
    {crc_en, mask_en, crc_ok} = 3'h6;
    u_ctl.wr(18'h00000, 4'h5);
    wait_idle();
    rd_chk(18'h00000, 9, 1'b0, 1'b0, 4'hA);
    at_clk();
    {crc_ok, arr_rdy} = 2'h2;
    u_ctl.wr(18'h00000, 4'h3);
    u_ctl.wr(18'h00000, 4'h5);
    repeat (20) @(negedge link_ck);
    `CHK(wr_busy, 1'b1)
    at_clk();
    arr_rdy = 1'b1;
    wait_idle();
    rd_chk(18'h00000, 9, 1'b0, 1'b0, 4'h5);
    at_clk();
    {crc_en, mask_en} = 2'h0;
    for (int c = 0; c < 7; c++)
    begin
      u_ctl.mrs(3'h0, {6'h0, c[2:0], 9'h0});
      u_ctl.wr(18'h00400, 4'h5);
      busy_len();
      if (c == 0)
        w0 = n;
      `CHK(n - w0, wtab[c] - 10)
      u_ctl.send(3'h5, 3'h0, 18'h00400);
      busy_len();
      if (c == 0)
        r0 = n;
      `CHK(n - r0, rtab[c] - 5)
    end
    u_ctl.mrs(3'h0, 18'h00002);
    u_ctl.wr(18'h00400, 4'h5);
    busy_len();
    `CHK(n, w0 - 2)
    u_ctl.mrs(3'h0, 18'h00001);
    u_ctl.wr(18'h00400, 4'h5);
    busy_len();
    `CHK(n, w0)
    give_verdict();
  end
endmodule : tb
